// File: rtl/ram_arb_defs.vh
// Purpose: shared constants for the shared RAM access arbiter
// Assumes: included by bare name from rtl files
// Notes:   definitions only
`ifndef RAM_ARB_DEFS_VH
`define RAM_ARB_DEFS_VH
`define DATA_W        8
`define BUS_ADDR_W    16
`define MEM_ADDR_W    14
`define BLOCK_SHIFT   11
`define BLOCK_BYTES   2048
`define BLOCK_IDX_W   3
`define NUM_BLOCKS    8
`define ROM_MASK_BYTES 2048
`define PROM_BYTES    256
`define RAM_BASE_BLK  3'h2
`define FIXED_BLKS    8'h0f
`define FIXED_SEL_RAM 8'h0c
`define REQ_CPU       0
`define REQ_RFSH      1
`define REQ_VID       2
`define REQ_CARD0     3
`define CYC_NS        20
`define CLK_NS        5
`define CYC_CLKS      ((`CYC_NS + `CLK_NS - 1) / `CLK_NS)
`define ST_IDLE       2'h0
`define ST_RUN        2'h1
`define ST_DONE       2'h2
`endif

// File: rtl/shared_ram_bank.v
// Purpose: shared RAM store, eight one-bit planes side by side
// Assumes: single clock, registered read data
// Notes:   one access per cycle, byte wide
`timescale 1ns/1ps
`include "ram_arb_defs.vh"
module shared_ram_bank #(
   parameter AW = 12                          // Word address width
) (
   input  wire              core_clk,         // System clock
   input  wire              en,               // Access enable
   input  wire              we,               // Write when high
   input  wire [AW-1:0]     addr,             // Word address
   input  wire [`DATA_W-1:0] wdata,           // Write byte
   output wire [`DATA_W-1:0] rdata            // Registered read byte
);
   genvar b;
   // Each plane is a 1-bit wide device, all driven in parallel
   generate
      for (b = 0; b < `DATA_W; b = b + 1) begin : plane
         reg mem [0:(1<<AW)-1];               // One bit plane
         reg q;                               // Registered bit out
         always @(posedge core_clk) begin
            if (en) begin
               if (we)
                  mem[addr] <= wdata[b];
               q <= mem[addr];
            end
         end
         assign rdata[b] = q;
      end
   endgenerate
endmodule // shared_ram_bank

// File: rtl/shared_ram_access_arbiter.v
// Purpose: fixed-priority arbiter for the shared memory bus and RAM
// Assumes: one clock, requesters synchronous to core_clk except the keyboard strobe, synchronised here
// Notes:   one RAM cycle at a time, no preemption
`timescale 1ns/1ps
`include "ram_arb_defs.vh"
module shared_ram_access_arbiter #(
   parameter NCARD = 4,                                // Peripheral card slots
   parameter RAM_AW = 12                               // RAM word address width (two 2K blocks)
) (
   input  wire                          core_clk,      // System clock
   input  wire                          nrst,          // Async reset, active low
   input  wire [`NUM_BLOCKS-1:0]        user_straps,   // User block-select straps
   input  wire                          cpu_req,       // CPU RAM cycle request
   input  wire                          cpu_we,        // CPU write
   input  wire [`BUS_ADDR_W-1:0]        cpu_addr,      // CPU address
   input  wire [`DATA_W-1:0]            cpu_wdata,     // CPU write data
   input  wire                          cpu_rom_fetch, // CPU fetching read-only segment
   output reg  [`BUS_ADDR_W-1:0]        rom_addr,      // Private read-only address path
   output reg                           rom_sel_mask,  // Mask ROM part selected
   output reg                           rom_sel_prom,  // PROM part selected
   input  wire                          rfsh_req,      // DRAM refresh request
   input  wire                          vid_req,       // Video refresh read request
   input  wire [`BUS_ADDR_W-1:0]        vid_addr,      // Video read address
   input  wire                          kbd_strobe,    // Keyboard strobe (pin)
   input  wire [`DATA_W-1:0]            kbd_code,      // Keyboard code (pins)
   input  wire [`BUS_ADDR_W-1:0]        kbd_addr,      // Keyboard input register address
   input  wire [NCARD-1:0]              card_req,      // Card requests, slot 0 highest
   input  wire [NCARD-1:0]              card_we,       // Card write flags
   input  wire [NCARD*`BUS_ADDR_W-1:0]  card_addr,     // Card addresses
   input  wire [NCARD*`DATA_W-1:0]      card_wdata,    // Card write data
   output reg  [NCARD+2:0]              grant,         // One-hot grant, held per cycle
   output reg                           cyc_done,      // Pulse: cycle finished
   output reg  [`DATA_W-1:0]            rdata,         // Read byte of finished cycle
   output reg                           block_miss,    // Last cycle hit no RAM block; never set by a refresh cycle
   output reg                           kbd_pending    // Keyboard byte waiting
);
   localparam NREQ = NCARD + 3;                        // Total requesters
   localparam CW = 4;                                  // Cycle counter width
   localparam [31:0] CYC_LAST = `CYC_CLKS - 1;         // Counter load; only the low CW bits are used

   reg  [1:0]              state;                      // Arbiter state
   reg  [CW-1:0]           cnt;                        // Cycle length counter
   reg  [NREQ-1:0]         next_grant;                 // Priority pick
   reg                     we_q;                       // Latched write
   reg  [`BUS_ADDR_W-1:0]  addr_q;                     // Latched bus address
   reg  [`DATA_W-1:0]      wd_q;                       // Latched write byte
   reg  [`DATA_W-1:0]      kbd_byte;                   // Keyboard holding buffer
   reg  [2:0]              kstb_sync;                  // Strobe synchroniser
   reg                     kstb_prev;                  // Agreed strobe level
   reg                     kbd_serve;                  // Current cycle is keyboard write
   reg                     ram_en;                     // RAM access strobe, combinational
   reg  [`NUM_BLOCKS-1:0]  blk_en;                     // Block enable map
   wire [`DATA_W-1:0]      ram_q;                      // RAM read byte
   wire [`BLOCK_IDX_W-1:0] blk;                        // Block index of bus address
   wire                    blk_hit;                    // Address lies in a RAM block
   wire [NREQ-1:0]         reqs;                       // All requests, priority order
   integer                 i;                          // Loop index, priority pick
   integer                 j;                          // Loop index, card latch
   wire [`MEM_ADDR_W-1:0]  ram_off;                    // Offset into the RAM window

   // Priority vector: index 0 highest
   assign reqs = {card_req, vid_req | kbd_pending, rfsh_req, cpu_req};

   // Fixed-priority pick; lowest index wins
   always @* begin
      next_grant = {NREQ{1'b0}};
      for (i = NREQ - 1; i >= 0; i = i - 1) begin
         if (reqs[i])
            next_grant = {{(NREQ-1){1'b0}}, 1'b1} << i;
      end
   end

   // Block decode: 2K blocks from 14-bit address, fixed map plus straps
   assign blk = addr_q[`MEM_ADDR_W-1:`BLOCK_SHIFT];
   always @* begin
      blk_en = (`FIXED_SEL_RAM & `FIXED_BLKS) | (user_straps & ~`FIXED_BLKS);
   end
   assign blk_hit = blk_en[blk] && (blk >= `RAM_BASE_BLK)
                    && (blk < `RAM_BASE_BLK + (1 << (RAM_AW - `BLOCK_SHIFT)));

   // Read-only path bypasses the bus; mask ROM low 2K, PROM pages above
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rom_addr     <= {`BUS_ADDR_W{1'b0}};
         rom_sel_mask <= 1'b0;
         rom_sel_prom <= 1'b0;
      end else begin
         rom_addr     <= cpu_addr;
         rom_sel_mask <= cpu_rom_fetch && (cpu_addr < `ROM_MASK_BYTES);
         rom_sel_prom <= cpu_rom_fetch && (cpu_addr >= `ROM_MASK_BYTES);
      end
   end

   // Keyboard strobe sync, three stages, change on stage 2/3 agreement
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         kstb_sync   <= 3'h0;
         kstb_prev   <= 1'b0;
         kbd_byte    <= 8'h00;
         kbd_pending <= 1'b0;
      end else begin
         kstb_sync <= {kstb_sync[1:0], kbd_strobe};
         if (kstb_sync[2] == kstb_sync[1])
            kstb_prev <= kstb_sync[2];
         // New strobe wins over the clearing at cycle end
         if (kstb_sync[2] == kstb_sync[1] && kstb_sync[2] && !kstb_prev) begin
            kbd_byte    <= kbd_code;
            kbd_pending <= 1'b1;
         end else if (state == `ST_DONE && kbd_serve) begin
            kbd_pending <= 1'b0;
         end
      end
   end

   // Cycle sequencer: pick at idle, hold grant until done
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state     <= `ST_IDLE;
         cnt       <= {CW{1'b0}};
         grant     <= {NREQ{1'b0}};
         we_q      <= 1'b0;
         addr_q    <= {`BUS_ADDR_W{1'b0}};
         wd_q      <= 8'h00;
         kbd_serve <= 1'b0;
         cyc_done  <= 1'b0;
         rdata     <= 8'h00;
         block_miss <= 1'b0;
      end else begin
         // Done is a one-cycle pulse
         cyc_done <= 1'b0;
         case (state)
            `ST_IDLE: begin
               kbd_serve <= 1'b0;
               if (|reqs) begin
                  grant <= next_grant;
                  state <= `ST_RUN;
                  cnt   <= CYC_LAST[CW-1:0];
                  we_q  <= 1'b0;
                  wd_q  <= 8'h00;
                  if (next_grant[`REQ_CPU]) begin
                     addr_q <= cpu_addr;
                     we_q   <= cpu_we;
                     wd_q   <= cpu_wdata;
                  end else if (next_grant[`REQ_RFSH]) begin
                     addr_q <= {`BUS_ADDR_W{1'b0}};    // Refresh needs no data
                  end else if (next_grant[`REQ_VID]) begin
                     // Keyboard write rides the video slot
                     if (kbd_pending) begin
                        addr_q    <= kbd_addr;
                        we_q      <= 1'b1;
                        wd_q      <= kbd_byte;
                        kbd_serve <= 1'b1;
                     end else begin
                        addr_q <= vid_addr;
                     end
                  end else begin
                     for (j = 0; j < NCARD; j = j + 1) begin
                        if (next_grant[`REQ_CARD0 + j]) begin
                           addr_q <= card_addr[j*`BUS_ADDR_W +: `BUS_ADDR_W];
                           we_q   <= card_we[j];
                           wd_q   <= card_wdata[j*`DATA_W +: `DATA_W];
                        end
                     end
                  end
               end
            end
            `ST_RUN: begin
               // Grant held; no preemption mid-cycle
               if (cnt == {CW{1'b0}}) begin
                  // RAM strobe is up during this cycle, see below
                  state  <= `ST_DONE;
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            `ST_DONE: begin
               rdata      <= ram_q;
               block_miss <= !grant[`REQ_RFSH] && !blk_hit;
               cyc_done   <= 1'b1;
               grant      <= {NREQ{1'b0}};
               state      <= `ST_IDLE;
            end
            default: state <= `ST_IDLE;
         endcase
      end
   end

   // RAM strobe on the last run edge, so read data settle before the done edge
   // A registered strobe here would hand stale data to rdata
   always @* begin
      ram_en = (state == `ST_RUN) && (cnt == {CW{1'b0}}) && !grant[`REQ_RFSH] && blk_hit;
   end

   // Window offset; only the low bits reach the planes
   assign ram_off = addr_q[`MEM_ADDR_W-1:0] - {`RAM_BASE_BLK, {`BLOCK_SHIFT{1'b0}}};

   // Byte-wide RAM from eight one-bit planes
   shared_ram_bank #(
      .AW (RAM_AW)
   ) u_ram (
      .core_clk (core_clk),
      .en       (ram_en),
      .we       (we_q),
      .addr     (ram_off[RAM_AW-1:0]),
      .wdata    (wd_q),
      .rdata    (ram_q)
   );
endmodule // shared_ram_access_arbiter

// File: tb/req_model.sv
// Purpose: requester side model, one level request per source
// Assumes: sources act on the falling clock edge
// Notes:   a request stays up until its own cycle ends
`timescale 1ns/1ps
module req_model #(
   parameter N = 7                  // Number of requesters
) (
   input  wire         core_clk,    // System clock
   input  wire         nrst,        // Reset, active low
   input  wire [N-1:0] go,          // Launch one request each
   input  wire [N-1:0] grant,       // Grants from the arbiter
   input  wire         cyc_done,    // Cycle finished
   output reg  [N-1:0] req          // Level requests
);
   reg [N-1:0] seen;                // Grant seen, cycle still open
   // Request held until its cycle ends; go raises each source whose bit is set, cards included
   always @(negedge core_clk or negedge nrst) begin
      if (!nrst) begin
         req  <= '0;
         seen <= '0;
      end else begin
         seen <= (seen | grant) & ~({N{cyc_done}} & seen);
         req  <= (req | go) & ~({N{cyc_done}} & seen);
      end
   end
endmodule // req_model

// File: tb/arb_checker_asserts.sv
// Purpose: port-level assertions on the arbiter
// Assumes: one clock, reset active low
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module arb_checker #(
   parameter NCARD = 4                  // Card slots
) (
   input wire             core_clk,     // System clock
   input wire             nrst,         // Reset, active low
   input wire             cpu_req,      // CPU request
   input wire             rfsh_req,     // Refresh request
   input wire             vid_req,      // Video request
   input wire             kbd_pending,  // Keyboard byte waiting
   input wire [NCARD-1:0] card_req,     // Card requests
   input wire [NCARD+2:0] grant,        // One-hot grant
   input wire             cyc_done,     // Cycle finished
   input wire             cpu_rom_fetch,// Read-only fetch
   input wire [15:0]      cpu_addr,     // CPU address
   input wire [15:0]      rom_addr,     // Private read-only path
   input wire             rom_sel_mask  // Mask part select
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // A pick is seen one edge after the requests that caused it
   one_grant_a: assert property ($onehot0(grant)) else $error("grant not one-hot");
   cpu_first_a: assert property ($rose(|grant) && $past(cpu_req) |-> grant[0])
      else $error("cpu lost a pick");
   rfsh_second_a: assert property ($rose(|grant) && $past(rfsh_req) && !$past(cpu_req) |-> grant[1])
      else $error("refresh lost a pick");
   vid_third_a: assert property ($rose(|grant) && $past(vid_req) && !$past(cpu_req || rfsh_req) |-> grant[2])
      else $error("video lost a pick");
   card_slot_a: assert property ($rose(|grant) && $past(card_req[0])
      && !$past(cpu_req || rfsh_req || vid_req || kbd_pending) |-> grant[3])
      else $error("slot zero lost a pick");
   // Grant stands four more samples, then done with grant gone
   hold_cycle_a: assert property ($rose(|grant) |=> $stable(grant)[*4] ##1 (cyc_done && grant == '0))
      else $error("cycle length or preemption");
   done_cause_a: assert property (cyc_done |-> $past(|grant) && grant == '0 ##1 !cyc_done)
      else $error("done without a cycle");
   rom_path_a: assert property (cpu_rom_fetch |=> rom_addr == $past(cpu_addr)
      && rom_sel_mask == ($past(cpu_addr) < 16'h0800))
      else $error("read-only path wrong");
   cover property ($rose(grant[0]));
   cover property ($rose(grant[NCARD+2]));
   cover property ($rose(grant[2]) && kbd_pending);
endmodule // arb_checker

// File: tb/tb_shared_ram_access_arbiter.sv
// Purpose: self-checking bench for the shared RAM arbiter
// Assumes: inputs change on the falling edge only
// Notes:   RAM sits at 0x1000-0x1fff, straps enable block 4 but it lies outside the RAM range and misses
`timescale 1ns/1ps
module tb_shared_ram_access_arbiter;
   reg         core_clk, nrst, cpu_we, cpu_rom_fetch, kbd_strobe; // Controls
   reg  [6:0]  go, seen_g;             // Launches, last grant seen
   reg  [15:0] cpu_addr, vid_addr, kbd_addr; // Addresses
   reg  [7:0]  cpu_wdata, kbd_code;    // Bytes
   reg  [3:0]  card_we;                // Card write flags
   reg  [63:0] card_addr;              // Packed card addresses
   reg  [31:0] card_wdata;             // Packed card bytes
   wire [6:0]  req, grant;             // Requests and grants
   wire [15:0] rom_addr;               // Read-only path
   wire [7:0]  rdata;                  // Read byte
   wire        cyc_done, block_miss, kbd_pending, rom_sel_mask, rom_sel_prom; // Status
   integer     errors, tests_run, i;   // Counters
   req_model #(.N(7)) model (.core_clk(core_clk), .nrst(nrst), .go(go), .grant(grant),
      .cyc_done(cyc_done), .req(req));
   shared_ram_access_arbiter dut (.core_clk(core_clk), .nrst(nrst), .user_straps(8'h10),
      .cpu_req(req[0]), .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
      .cpu_rom_fetch(cpu_rom_fetch), .rom_addr(rom_addr), .rom_sel_mask(rom_sel_mask),
      .rom_sel_prom(rom_sel_prom), .rfsh_req(req[1]), .vid_req(req[2]), .vid_addr(vid_addr),
      .kbd_strobe(kbd_strobe), .kbd_code(kbd_code), .kbd_addr(kbd_addr), .card_req(req[6:3]),
      .card_we(card_we), .card_addr(card_addr), .card_wdata(card_wdata), .grant(grant),
      .cyc_done(cyc_done), .rdata(rdata), .block_miss(block_miss), .kbd_pending(kbd_pending));
   // Free-running clock, 5 ns
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   task test_done;
      begin
         $display("errors=%0d tests_run=%0d", errors, tests_run);
         if (errors == 0 && tests_run > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // Waits for the next done pulse, bounded; remembers the grant
   task wait_done;
      integer n;
      begin
         seen_g = 7'h00;
         n = 0;
         do begin
            @(negedge core_clk);
            if (grant !== 7'h00) seen_g = grant;
            n = n + 1;
         end while (cyc_done !== 1'b1 && n < 200);
         if (cyc_done !== 1'b1) begin
            chk(16'h0000, 16'h0001);
            test_done;
         end
      end
   endtask
   // Same fields for the CPU and all four cards; go held one full cycle
   task launch(input [6:0] m, input w, input [15:0] a, input [7:0] d);
      begin
         @(negedge core_clk);
         {cpu_we, cpu_addr, cpu_wdata} <= {w, a, d};
         {card_we, card_addr, card_wdata} <= {{4{w}}, {4{a}}, {4{d}}};
         go <= m;
         @(negedge core_clk);
         go <= 7'h00;
      end
   endtask
   task cyc(input [6:0] m, input w, input [15:0] a, input [7:0] d);
      begin
         launch(m, w, a, d);
         wait_done;
      end
   endtask
   task t_order;
      begin
         launch(7'h7f, 1'b0, 16'h1100, 8'h00);
         for (i = 0; i < 7; i = i + 1) begin
            wait_done;
            chk(seen_g, 7'h01 << i);
         end
      end
   endtask
   task t_preempt;
      begin
         launch(7'h40, 1'b0, 16'h1100, 8'h00);
         repeat (2) @(negedge core_clk);
         launch(7'h01, 1'b0, 16'h1100, 8'h00);
         wait_done;
         chk(seen_g, 7'h40);
         wait_done;
         chk(seen_g, 7'h01);
      end
   endtask
   task t_rw;
      begin
         cyc(7'h01, 1'b1, 16'h1234, 8'h5a);
         cyc(7'h40, 1'b0, 16'h1234, 8'h00);
         chk(rdata, 8'h5a);
         chk(block_miss, 1'b0);
         cyc(7'h10, 1'b1, 16'h1fff, 8'ha5);
         cyc(7'h01, 1'b0, 16'h1fff, 8'h00);
         chk(rdata, 8'ha5);
         cyc(7'h08, 1'b0, 16'h2000, 8'h00);
         chk(block_miss, 1'b1);
         cyc(7'h08, 1'b0, 16'h0fff, 8'h00);
         chk(block_miss, 1'b1);
      end
   endtask
   task t_kbd;
      begin
         kbd_strobe <= 1'b1;
         repeat (4) @(negedge core_clk);
         chk(kbd_pending, 1'b1);
         wait_done;
         chk(seen_g, 7'h04);
         chk(kbd_pending, 1'b0);
         kbd_strobe <= 1'b0;
         cyc(7'h01, 1'b0, 16'h1800, 8'h00);
         chk(rdata, 8'h41);
      end
   endtask
   task t_rom;
      begin
         cpu_rom_fetch <= 1'b1;
         cyc(7'h20, 1'b0, 16'h1234, 8'h00);
         chk(seen_g, 7'h20);
         chk(rdata, 8'h5a);
         chk(rom_addr, 16'h1234);
         chk(rom_sel_mask, 1'b0);
         chk(rom_sel_prom, 1'b1);
         cpu_addr <= 16'h0100;
         repeat (2) @(negedge core_clk);
         chk(rom_sel_mask, 1'b1);
         chk(rom_sel_prom, 1'b0);
         chk(rom_addr, 16'h0100);
      end
   endtask
   // Main sequence: reset five cycles, then each scenario
   initial begin
      {nrst, cpu_we, cpu_rom_fetch, kbd_strobe, go} = 11'h000;
      {cpu_addr, cpu_wdata, card_we, card_addr, card_wdata} = 124'h0;
      {vid_addr, kbd_addr, kbd_code} = {16'h1100, 16'h1800, 8'h41};
      {errors, tests_run} = {32'h0, 32'h0};
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      nrst <= 1'b1;
      t_order;
      t_preempt;
      t_rw;
      t_kbd;
      t_rom;
      test_done;
   end
endmodule // tb_shared_ram_access_arbiter
bind shared_ram_access_arbiter arb_checker #(.NCARD(NCARD)) chk_i (.core_clk(core_clk), .nrst(nrst),
   .cpu_req(cpu_req), .rfsh_req(rfsh_req), .vid_req(vid_req), .kbd_pending(kbd_pending),
   .card_req(card_req), .grant(grant), .cyc_done(cyc_done), .cpu_rom_fetch(cpu_rom_fetch),
   .cpu_addr(cpu_addr), .rom_addr(rom_addr), .rom_sel_mask(rom_sel_mask));
